/* core/sea_top.sv */
// The address map and the APB slave port were left to the implementer.
`default_nettype none
module sea_top import sea_pkg::*; #(
	parameter int unsigned ERR_W = 32
) (
	// clock and power-on reset
	input wire logic                  mclk,
	input wire logic                  rst,
	// apb slave
	input wire logic [ADDR_W-1:0]     paddr,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [DATA_W-1:0]     pwdata,
	input wire logic [STRB_W-1:0]     pstrb,
	output logic [DATA_W-1:0]         prdata,
	output logic                      pready,
	output logic                      pslverr,
	// error sources
	input wire logic [ERR_W-1:0]      platform_mgmt_controller_err1,
	input wire logic [ERR_W-1:0]      platform_mgmt_controller_err2,
	input wire logic [ERR_W-1:0]      low_power_domain_err1,
	input wire logic [ERR_W-1:0]      low_power_domain_err2,
	// management side actions
	output logic                      por_req,
	output logic                      system_reset_request,
	output logic                      error_out_pin,
	output logic                      platform_mgmt_controller_irq,
	// low power side interrupts
	output logic                      processing_system_manager_irq_gen,
	output logic                      processing_system_manager_irq_cor,
	output logic                      processing_system_manager_irq_unc,
	// jtag error register
	output logic [2*ERR_W-1:0]        jtag_err_status,
	// fabric export
	output logic [2*ERR_W-1:0]        programmable_logic_fabric_mgmt_status,
	output logic [2*ERR_W-1:0]        programmable_logic_fabric_lpwr_status,
	output logic [N_SET-1:0]          programmable_logic_fabric_actions,
	// block interrupt
	output logic                      blk_irq
);
	if (ERR_W < 1 || ERR_W > DATA_W) begin : g_chk
		$error("ERR_W must lie in 1..32");
	end
	if (DATA_W != 32 || STRB_W * 8 != DATA_W) begin : g_chk_bus
		$error("register bus must be 32 bits with byte strobes");
	end

	// counts that the wiring below is written for
	if (N_STAT != 4) begin : g_chk_stat
		$error("wiring expects two status registers per side");
	end
	if (N_MASK != 2 * N_SET) begin : g_chk_mask
		$error("each mask set needs one mask per status register");
	end
	if (ACT_UNC_IRQ + 1 != N_SET || ACT_MGMT_IRQ + 1 != N_MGMT_SET) begin : g_chk_act
		$error("action indices do not cover every mask set");
	end
	if (EVT_BUS_ERR >= N_EVT || N_EVT > DATA_W) begin : g_chk_evt
		$error("event bits do not fit the event registers");
	end

	// register pages must not overlap
	if (ADDR_MGMT_SET0 + N_MGMT_SET * SET_STRIDE > ADDR_LPWR_STAT) begin : g_chk_mgmt_map
		$error("management mask sets run into the low power page");
	end
	if (ADDR_LPWR_SET0 + N_LPWR_SET * SET_STRIDE > ADDR_EVT_STAT) begin : g_chk_lpwr_map
		$error("low power mask sets run into the event registers");
	end
	if (ADDR_MGMT_SWERR >= ADDR_MGMT_SET0 || ADDR_LPWR_SWERR >= ADDR_LPWR_SET0) begin : g_chk_sw
		$error("software trigger falls inside a mask set");
	end
	if (OFF_DISABLE + HALF_STRIDE >= SET_STRIDE) begin : g_chk_half
		$error("second half of a mask set exceeds its stride");
	end

	// address of status register i
	function automatic logic [ADDR_W-1:0] stat_addr(input int unsigned i);
		logic [ADDR_W-1:0] base;
		base = (i < 2) ? ADDR_MGMT_STAT : ADDR_LPWR_STAT;
		return base + (((i % 2) == 1) ? STAT_STRIDE : '0);
	endfunction : stat_addr

	// address of mask register m at offset off
	function automatic logic [ADDR_W-1:0] mask_addr(input int unsigned m,
		input logic [ADDR_W-1:0] off);
		int unsigned      s;
		logic [ADDR_W-1:0] base;
		s = m / 2;
		if (s < N_MGMT_SET) begin
			base = ADDR_MGMT_SET0 + ADDR_W'(s) * SET_STRIDE;
		end else begin
			base = ADDR_LPWR_SET0 + ADDR_W'(s - N_MGMT_SET) * SET_STRIDE;
		end
		return base + (((m % 2) == 1) ? HALF_STRIDE : '0) + off;
	endfunction : mask_addr

	// status register that mask m gates
	function automatic int unsigned stat_of(input int unsigned m);
		return (((m / 2) < N_MGMT_SET) ? 0 : 2) + (m % 2);
	endfunction : stat_of

	logic [ERR_W-1:0]  err_in   [N_STAT];
	logic [ERR_W-1:0]  sw_in    [N_STAT];
	logic [ERR_W-1:0]  stat_q   [N_STAT];
	logic [N_STAT-1:0] new_evt;
	logic [ERR_W-1:0]  mask_q   [N_MASK];
	logic [N_MASK-1:0] mask_hit;
	logic [N_SET-1:0]  act_d;
	logic [N_SET-1:0]  act_q;

	logic [DATA_W-1:0] wdata_eff;
	logic              setup_ph;
	logic              access_ph;
	logic              wr_acc;
	logic              dec_hit;
	logic              dec_ro;
	logic [DATA_W-1:0] rd_val;
	logic [N_STAT-1:0] wr_stat_v;
	logic [N_MASK-1:0] wr_en_v;
	logic [N_MASK-1:0] wr_dis_v;
	logic [1:0]        wr_sw_v;
	logic              wr_evt_clr_v;
	logic              wr_evt_en_v;
	logic [DATA_W-1:0] prdata_q;
	logic              slverr_q;

	logic [N_EVT-1:0]  evt;
	logic [N_EVT-1:0]  evt_clr;
	logic [N_EVT-1:0]  evt_stat_q;
	logic [N_EVT-1:0]  evt_en_q;
	logic              blk_irq_q;

	sea_wr_if stat_if [N_STAT] ();
	sea_wr_if en_if   [N_MASK] ();
	sea_wr_if dis_if  [N_MASK] ();

	// error source wiring, one status register per source
	assign err_in[0] = platform_mgmt_controller_err1;
	assign err_in[1] = platform_mgmt_controller_err2;
	assign err_in[2] = low_power_domain_err1;
	assign err_in[3] = low_power_domain_err2;

	// software raised errors land in the first status reg of each side
	assign sw_in[0] = wr_acc && wr_sw_v[0] ? wdata_eff[ERR_W-1:0] : '0;
	assign sw_in[1] = '0;
	assign sw_in[2] = wr_acc && wr_sw_v[1] ? wdata_eff[ERR_W-1:0] : '0;
	assign sw_in[3] = '0;

	// apb phases and byte lanes
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign pready    = access_ph;
	assign wr_acc    = access_ph & pwrite & dec_hit & ~dec_ro;
	assign pslverr   = access_ph & slverr_q;
	assign prdata    = prdata_q;

	for (genvar b = 0; b < STRB_W; b++) begin : g_lane
		assign wdata_eff[8*b +: 8] = pstrb[b] ? pwdata[8*b +: 8] : 8'h00;
	end

	// address decode
	always_comb begin
		dec_hit      = 1'b0;
		dec_ro       = 1'b0;
		rd_val       = '0;
		wr_stat_v    = '0;
		wr_en_v      = '0;
		wr_dis_v     = '0;
		wr_sw_v      = '0;
		wr_evt_clr_v = 1'b0;
		wr_evt_en_v  = 1'b0;
		if (paddr == ADDR_EVT_STAT) begin
			dec_hit = 1'b1;
			dec_ro  = 1'b1;
			rd_val  = DATA_W'(evt_stat_q);
		end else if (paddr == ADDR_EVT_CLR) begin
			dec_hit      = 1'b1;
			wr_evt_clr_v = 1'b1;
		end else if (paddr == ADDR_EVT_EN) begin
			dec_hit     = 1'b1;
			wr_evt_en_v = 1'b1;
			rd_val      = DATA_W'(evt_en_q);
		end else if (paddr == ADDR_MGMT_SWERR) begin
			dec_hit    = 1'b1;
			wr_sw_v[0] = 1'b1;
		end else if (paddr == ADDR_LPWR_SWERR) begin
			dec_hit    = 1'b1;
			wr_sw_v[1] = 1'b1;
		end else begin
			for (int unsigned i = 0; i < N_STAT; i++) begin
				if (paddr == stat_addr(i)) begin
					dec_hit      = 1'b1;
					wr_stat_v[i] = 1'b1;
					rd_val       = DATA_W'(stat_q[i]);
				end
			end
			for (int unsigned m = 0; m < N_MASK; m++) begin
				if (paddr == mask_addr(m, OFF_MASK)) begin
					// direct mask writes refused
					dec_hit = 1'b1;
					dec_ro  = 1'b1;
					rd_val  = DATA_W'(mask_q[m]);
				end
				if (paddr == mask_addr(m, OFF_ENABLE)) begin
					dec_hit     = 1'b1;
					wr_en_v[m]  = 1'b1;
				end
				if (paddr == mask_addr(m, OFF_DISABLE)) begin
					dec_hit     = 1'b1;
					wr_dis_v[m] = 1'b1;
				end
			end
		end
	end

	// read data and error captured in setup, shown in access
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata_q <= '0;
			slverr_q <= 1'b0;
		end else if (setup_ph) begin
			prdata_q <= pwrite ? '0 : rd_val;
			slverr_q <= ~dec_hit | (pwrite & dec_ro);
		end
	end

	// status banks
	for (genvar i = 0; i < N_STAT; i++) begin : g_stat
		assign stat_if[i].we    = wr_acc & wr_stat_v[i];
		assign stat_if[i].wdata = wdata_eff;
		sea_status_bank #(
			.ERR_W (ERR_W)
		) u_bank (
			.mclk     (mclk),
			.rst      (rst),
			.clr_wr   (stat_if[i]),
			.err_in   (err_in[i]),
			.sw_in    (sw_in[i]),
			.status_q (stat_q[i]),
			.new_evt  (new_evt[i])
		);
	end

	// mask registers, two per action set
	for (genvar m = 0; m < N_MASK; m++) begin : g_mask
		assign en_if[m].we     = wr_acc & wr_en_v[m];
		assign en_if[m].wdata  = wdata_eff;
		assign dis_if[m].we    = wr_acc & wr_dis_v[m];
		assign dis_if[m].wdata = wdata_eff;
		sea_mask_reg #(
			.ERR_W (ERR_W)
		) u_mask (
			.mclk   (mclk),
			.rst    (rst),
			.en_wr  (en_if[m]),
			.dis_wr (dis_if[m]),
			.status (stat_q[stat_of(m)]),
			.mask_q (mask_q[m]),
			.hit    (mask_hit[m])
		);
	end

	// one action per mask set
	for (genvar s = 0; s < N_SET; s++) begin : g_act
		assign act_d[s] = mask_hit[2*s] | mask_hit[2*s+1];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			act_q <= '0;
		end else begin
			act_q <= act_d;
		end
	end

	assign por_req                           = act_q[ACT_POR];
	assign system_reset_request              = act_q[ACT_SYSTEM_RESET_REQUEST];
	assign error_out_pin                     = act_q[ACT_ERR_PIN];
	assign platform_mgmt_controller_irq      = act_q[ACT_MGMT_IRQ];
	assign processing_system_manager_irq_gen = act_q[ACT_GEN_IRQ];
	assign processing_system_manager_irq_cor = act_q[ACT_COR_IRQ];
	assign processing_system_manager_irq_unc = act_q[ACT_UNC_IRQ];

	// status export straight from the sticky flops
	assign jtag_err_status = {stat_q[1], stat_q[0]};
	assign programmable_logic_fabric_mgmt_status = {stat_q[1], stat_q[0]};
	assign programmable_logic_fabric_lpwr_status = {stat_q[3], stat_q[2]};
	assign programmable_logic_fabric_actions     = act_q;

	// block interrupt events
	assign evt[EVT_MGMT_ERR] = |new_evt[1:0];
	assign evt[EVT_LPWR_ERR] = |new_evt[3:2];
	assign evt[EVT_BUS_ERR]  = pslverr;
	assign evt_clr = (wr_acc & wr_evt_clr_v) ? wdata_eff[N_EVT-1:0] : '0;

	always_ff @(posedge mclk) begin
		if (rst) begin
			evt_stat_q <= '0;
		end else begin
			evt_stat_q <= (evt_stat_q & ~evt_clr) | evt;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			evt_en_q <= EVT_EN_RST;
		end else if (wr_acc && wr_evt_en_v && pstrb[0]) begin
			evt_en_q <= pwdata[N_EVT-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			blk_irq_q <= 1'b0;
		end else begin
			blk_irq_q <= |(evt_stat_q & evt_en_q);
		end
	end

	assign blk_irq = blk_irq_q;
endmodule : sea_top
`default_nettype wire

/* core/sea_pkg.sv */
`default_nettype none
package sea_pkg;
	// bus geometry
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned STRB_W = DATA_W / 8;

	// accumulator shape: status regs 0,1 management side, 2,3 low power side
	localparam int unsigned N_STAT     = 4;
	localparam int unsigned N_MGMT_SET = 4;
	localparam int unsigned N_LPWR_SET = 3;
	localparam int unsigned N_SET      = N_MGMT_SET + N_LPWR_SET;
	localparam int unsigned N_MASK     = 2 * N_SET;
	localparam int unsigned N_EVT      = 3;

	// action (mask set) index
	localparam int unsigned ACT_POR     = 0;
	localparam int unsigned ACT_SYSTEM_RESET_REQUEST    = 1;
	localparam int unsigned ACT_ERR_PIN = 2;
	localparam int unsigned ACT_MGMT_IRQ = 3;
	localparam int unsigned ACT_GEN_IRQ = 4;
	localparam int unsigned ACT_COR_IRQ = 5;
	localparam int unsigned ACT_UNC_IRQ = 6;

	// block interrupt event bits
	localparam int unsigned EVT_MGMT_ERR = 0;
	localparam int unsigned EVT_LPWR_ERR = 1;
	localparam int unsigned EVT_BUS_ERR  = 2;

	// register map, byte addresses
	localparam logic [ADDR_W-1:0] ADDR_MGMT_STAT  = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_MGMT_SWERR = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_MGMT_SET0  = 12'h020;
	localparam logic [ADDR_W-1:0] ADDR_LPWR_STAT  = 12'h100;
	localparam logic [ADDR_W-1:0] ADDR_LPWR_SWERR = 12'h108;
	localparam logic [ADDR_W-1:0] ADDR_LPWR_SET0  = 12'h120;
	localparam logic [ADDR_W-1:0] ADDR_EVT_STAT   = 12'h200;
	localparam logic [ADDR_W-1:0] ADDR_EVT_CLR    = 12'h204;
	localparam logic [ADDR_W-1:0] ADDR_EVT_EN     = 12'h208;
	localparam logic [ADDR_W-1:0] STAT_STRIDE     = 12'h004;
	localparam logic [ADDR_W-1:0] SET_STRIDE      = 12'h020;
	localparam logic [ADDR_W-1:0] HALF_STRIDE     = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_MASK        = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_ENABLE      = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_DISABLE     = 12'h008;

	// reset values
	localparam logic [DATA_W-1:0] STAT_RST   = 32'h0000_0000;
	localparam logic [DATA_W-1:0] MASK_RST   = 32'hFFFF_FFFF;
	localparam logic [N_EVT-1:0]  EVT_EN_RST = 3'h0;
endpackage : sea_pkg
`default_nettype wire

/* core/sea_wr_if.sv */
`default_nettype none
interface sea_wr_if;
	import sea_pkg::*;
	logic              we;
	logic [DATA_W-1:0] wdata;
	modport src (output we, output wdata);
	modport dst (input we, input wdata);
endinterface : sea_wr_if
`default_nettype wire

/* core/sea_status_bank.sv */
`default_nettype none
module sea_status_bank import sea_pkg::*; #(
	parameter int unsigned ERR_W = 32
) (
	// clock and power-on reset
	input wire logic             mclk,
	input wire logic             rst,
	// software clear
	sea_wr_if.dst                clr_wr,
	// error sources
	input wire logic [ERR_W-1:0] err_in,
	input wire logic [ERR_W-1:0] sw_in,
	// state
	output logic [ERR_W-1:0]     status_q,
	output logic                 new_evt
);
	logic [ERR_W-1:0] clr_bits;
	logic [ERR_W-1:0] set_bits;
	logic [ERR_W-1:0] status_d;

	assign clr_bits = clr_wr.we ? clr_wr.wdata[ERR_W-1:0] : '0;
	assign set_bits = err_in | sw_in;
	// set beats clear
	assign status_d = (status_q & ~clr_bits) | set_bits;
	assign new_evt  = |(set_bits & ~status_q);

	// only power-on reset clears, system reset does not reach here
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_q <= STAT_RST[ERR_W-1:0];
		end else begin
			status_q <= status_d;
		end
	end
endmodule : sea_status_bank
`default_nettype wire

/* core/sea_mask_reg.sv */
`default_nettype none
module sea_mask_reg import sea_pkg::*; #(
	parameter int unsigned ERR_W = 32
) (
	// clock and power-on reset
	input wire logic             mclk,
	input wire logic             rst,
	// enable and disable writes
	sea_wr_if.dst                en_wr,
	sea_wr_if.dst                dis_wr,
	// status gated
	input wire logic [ERR_W-1:0] status,
	output logic [ERR_W-1:0]     mask_q,
	output logic                 hit
);
	logic [ERR_W-1:0] en_bits;
	logic [ERR_W-1:0] dis_bits;

	assign en_bits  = en_wr.we ? en_wr.wdata[ERR_W-1:0] : '0;
	assign dis_bits = dis_wr.we ? dis_wr.wdata[ERR_W-1:0] : '0;
	assign hit      = |(status & ~mask_q);

	always_ff @(posedge mclk) begin
		if (rst) begin
			mask_q <= MASK_RST[ERR_W-1:0];
		end else begin
			mask_q <= (mask_q & ~en_bits) | dis_bits;
		end
	end
endmodule : sea_mask_reg
`default_nettype wire

/* dv/sea_err_src.sv */
`default_nettype none
module sea_err_src import sea_pkg::*; #(
	parameter int unsigned ERR_W = 32
) (
	// clock
	input wire logic         mclk,
	// error lines
	output logic [ERR_W-1:0] mgmt1,
	output logic [ERR_W-1:0] mgmt2,
	output logic [ERR_W-1:0] lpwr1,
	output logic [ERR_W-1:0] lpwr2
);
	logic [ERR_W-1:0] lvl[4] = '{default: '0};
	logic [ERR_W-1:0] lvl_q[4] = '{default: '0};

	// one level per source, replaced on each drive and held until the next
	task automatic drive(input int s, input logic [ERR_W-1:0] v);
		lvl[s] <= v;
	endtask : drive

	always @(posedge mclk) lvl_q <= lvl;
	assign mgmt1 = lvl_q[0];
	assign mgmt2 = lvl_q[1];
	assign lpwr1 = lvl_q[2];
	assign lpwr2 = lvl_q[3];
endmodule : sea_err_src
`default_nettype wire

/* dv/sea_properties.sv */
`default_nettype none
module sea_properties import sea_pkg::*; #(
	parameter int unsigned ERR_W = 32
) (
	// clock, reset, bus
	input wire logic               mclk,
	input wire logic               rst,
	input wire logic [ADDR_W-1:0]  paddr,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic               pready,
	input wire logic               pslverr,
	// sources and state
	input wire logic [ERR_W-1:0]   platform_mgmt_controller_err1,
	input wire logic [ERR_W-1:0]   platform_mgmt_controller_err2,
	input wire logic [ERR_W-1:0]   low_power_domain_err1,
	input wire logic [ERR_W-1:0]   low_power_domain_err2,
	input wire logic [2*ERR_W-1:0] jtag_err_status,
	input wire logic [2*ERR_W-1:0] programmable_logic_fabric_mgmt_status,
	input wire logic [2*ERR_W-1:0] programmable_logic_fabric_lpwr_status,
	input wire logic [N_SET-1:0]   programmable_logic_fabric_actions,
	// actions
	input wire logic               por_req,
	input wire logic               system_reset_request,
	input wire logic               error_out_pin,
	input wire logic               platform_mgmt_controller_irq,
	input wire logic               processing_system_manager_irq_gen,
	input wire logic               processing_system_manager_irq_cor,
	input wire logic               processing_system_manager_irq_unc
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	logic                wr_acc;
	logic [2*ERR_W-1:0]  m_err;
	logic [2*ERR_W-1:0]  l_err;
	assign wr_acc = psel && penable && pwrite;
	assign m_err  = {platform_mgmt_controller_err2, platform_mgmt_controller_err1};
	assign l_err  = {low_power_domain_err2, low_power_domain_err1};

	sequence unmapped_setup;
		psel && !penable && paddr == 12'h300 ##1 psel && penable;
	endsequence

	chk_mgmt_err_latch: assert property (
		1'b1 |=> (jtag_err_status & $past(m_err)) == $past(m_err))
		else $error("mgmt error not latched");
	chk_lpwr_err_latch: assert property (
		1'b1 |=> (programmable_logic_fabric_lpwr_status & $past(l_err)) == $past(l_err))
		else $error("low power error not latched");
	chk_sticky_status: assert property (
		!(wr_acc && paddr[11:8] == 4'h0) |=> (jtag_err_status & $past(jtag_err_status))
		== $past(jtag_err_status)) else $error("mgmt status bit lost");
	chk_new_bit_cause: assert property (
		(jtag_err_status & ~$past(jtag_err_status)) != 0 |->
		$past(m_err) != 0 || $past(wr_acc && paddr == ADDR_MGMT_SWERR))
		else $error("mgmt bit set without cause");
	chk_jtag_export: assert property (
		programmable_logic_fabric_mgmt_status == jtag_err_status)
		else $error("fabric and jtag status differ");
	chk_mgmt_act_cause: assert property (
		por_req || system_reset_request || error_out_pin || platform_mgmt_controller_irq
		|-> $past(jtag_err_status) != 0) else $error("mgmt action without status");
	chk_lpwr_act_cause: assert property (
		processing_system_manager_irq_gen || processing_system_manager_irq_cor
		|| processing_system_manager_irq_unc |-> $past(programmable_logic_fabric_lpwr_status) != 0)
		else $error("low power irq without status");
	chk_action_vector: assert property (
		programmable_logic_fabric_actions == {processing_system_manager_irq_unc,
		processing_system_manager_irq_cor, processing_system_manager_irq_gen,
		platform_mgmt_controller_irq, error_out_pin, system_reset_request, por_req})
		else $error("fabric action vector wrong");
	chk_zero_wait: assert property (pready == (psel && penable))
		else $error("pready timing wrong");
	chk_unmapped_err: assert property (unmapped_setup |-> pslverr)
		else $error("unmapped access not refused");
endmodule : sea_properties

bind sea_top sea_properties #(.ERR_W(ERR_W)) i_props (.mclk, .rst, .paddr, .psel, .penable,
	.pwrite, .pready, .pslverr, .platform_mgmt_controller_err1, .platform_mgmt_controller_err2,
	.low_power_domain_err1, .low_power_domain_err2, .jtag_err_status,
	.programmable_logic_fabric_mgmt_status, .programmable_logic_fabric_lpwr_status,
	.programmable_logic_fabric_actions, .por_req, .system_reset_request, .error_out_pin,
	.platform_mgmt_controller_irq, .processing_system_manager_irq_gen,
	.processing_system_manager_irq_cor, .processing_system_manager_irq_unc);
`default_nettype wire

/* dv/tb_top.sv */
`default_nettype none
module tb_top import sea_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned EW = 8;
	logic              mclk, rst, psel, penable, pwrite, pready, pslverr, se, blk_irq;
	logic [ADDR_W-1:0] paddr, hoff;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [STRB_W-1:0] pstrb;
	logic [EW-1:0]     me1, me2, le1, le2, b;
	logic [2*EW-1:0]   jtag, fms, fls;
	logic [N_SET-1:0]  acts;
	logic [6:0]        act;
	int                errors, samples_checked, seed, cyc, s;

	sea_top #(.ERR_W(EW)) i_dut (.mclk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .platform_mgmt_controller_err1(me1),
		.platform_mgmt_controller_err2(me2), .low_power_domain_err1(le1),
		.low_power_domain_err2(le2), .por_req(act[0]), .system_reset_request(act[1]),
		.error_out_pin(act[2]), .platform_mgmt_controller_irq(act[3]),
		.processing_system_manager_irq_gen(act[4]), .processing_system_manager_irq_cor(act[5]),
		.processing_system_manager_irq_unc(act[6]), .jtag_err_status(jtag),
		.programmable_logic_fabric_mgmt_status(fms), .programmable_logic_fabric_lpwr_status(fls),
		.programmable_logic_fabric_actions(acts), .blk_irq);
	sea_err_src #(.ERR_W(EW)) i_src (.mclk, .mgmt1(me1), .mgmt2(me2), .lpwr1(le1), .lpwr2(le2));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic wrap_up();
		if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic pulse(input int src, input logic [EW-1:0] v);
		i_src.drive(src, v);
		repeat (2) @(posedge mclk);
		i_src.drive(src, '0);
		repeat (3) @(posedge mclk);
	endtask : pulse

	function automatic logic [ADDR_W-1:0] stat_a(input int t);
		return t < 2 ? ADDR_MGMT_STAT + 12'(t) * STAT_STRIDE : ADDR_LPWR_STAT + 12'(t - 2) * STAT_STRIDE;
	endfunction : stat_a

	function automatic logic [ADDR_W-1:0] set_a(input int k);
		return k < 4 ? ADDR_MGMT_SET0 + 12'(k) * SET_STRIDE : ADDR_LPWR_SET0 + 12'(k - 4) * SET_STRIDE;
	endfunction : set_a

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end

	initial begin
		{seed, errors, samples_checked, cyc} = {32'd16, 96'd0};
		{rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 44'h0, 4'hF};
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		for (int k = 0; k < N_SET; k++) begin
			apb(1'b0, set_a(k) + OFF_MASK, 32'h0);
			chk(rd, 32'hFF);
			apb(1'b0, set_a(k) + HALF_STRIDE + OFF_MASK, 32'h0);
			chk(rd, 32'hFF);
		end
		// each source reaches only its own bank
		for (int t = 0; t < 4; t++) begin
			b = EW'(1) << ($unsigned($random(seed)) % EW);
			pulse(t, b);
			for (int u = 0; u < 4; u++) begin
				apb(1'b0, stat_a(u), 32'h0);
				chk(rd, u == t ? 32'(b) : 32'h0);
			end
			apb(1'b1, stat_a(t), 32'(b));
			apb(1'b0, stat_a(t), 32'h0);
			chk(rd, 32'h0);
		end
		for (int k = 0; k < N_SET; k++) begin
			s = (k < 4 ? 0 : 2) + k % 2;
			hoff = k % 2 == 1 ? HALF_STRIDE : 12'h000;
			b = EW'(1) << ($unsigned($random(seed)) % EW);
			apb(1'b1, set_a(k) + hoff + OFF_ENABLE, 32'(b));
			apb(1'b1, set_a(k) + hoff + OFF_MASK, 32'h0);
			chk(32'(se), 32'h1);
			apb(1'b0, set_a(k) + hoff + OFF_MASK, 32'h0);
			chk(rd, 32'(b ^ {EW{1'b1}}));
			pulse(s, b);
			chk(32'(acts), 32'h1 << k);
			chk(32'(act), 32'h1 << k);
			apb(1'b0, stat_a(s), 32'h0);
			chk(rd, 32'(b));
			apb(1'b1, set_a(k) + hoff + OFF_DISABLE, 32'(b));
			repeat (2) @(posedge mclk);
			chk(32'(acts), 32'h0);
			apb(1'b1, stat_a(s), 32'(b));
		end
		// clear racing a held error
		i_src.drive(1, 8'h80);
		repeat (3) @(posedge mclk);
		apb(1'b1, stat_a(1), 32'h80);
		apb(1'b0, stat_a(1), 32'h0);
		chk(rd, 32'h80);
		i_src.drive(1, '0);
		repeat (2) @(posedge mclk);
		apb(1'b1, stat_a(1), 32'h80);
		apb(1'b1, ADDR_MGMT_SWERR, 32'h5);
		apb(1'b0, ADDR_MGMT_STAT, 32'h0);
		chk(rd, 32'h5);
		apb(1'b1, ADDR_LPWR_SWERR, 32'hA);
		apb(1'b0, ADDR_LPWR_STAT, 32'h0);
		chk(rd, 32'hA);
		apb(1'b1, ADDR_MGMT_STAT, 32'h5);
		apb(1'b1, ADDR_LPWR_STAT, 32'hA);
		apb(1'b1, ADDR_EVT_CLR, 32'h7);
		apb(1'b1, ADDR_EVT_EN, 32'h1);
		pulse(0, 8'h02);
		chk(32'(blk_irq), 32'h1);
		apb(1'b1, ADDR_EVT_EN, 32'h0);
		repeat (2) @(posedge mclk);
		chk(32'(blk_irq), 32'h0);
		apb(1'b0, 12'h300, 32'h0);
		chk({rd[30:0], se}, 32'h1);
		apb(1'b0, ADDR_EVT_STAT, 32'h0);
		chk(rd, 32'h5);
		apb(1'b1, stat_a(0), 32'h02);
		apb(1'b1, ADDR_EVT_CLR, 32'h7);
		apb(1'b0, ADDR_EVT_STAT, 32'h0);
		chk(rd, 32'h0);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
